/* File: lhc_pkg.sv */
// package with register indices, fields and constants for the lcd start centering block
package lhc_pkg;
  // ----------------------------------------
  // register indices
  // ----------------------------------------
  localparam logic [7:0] LHC_IDX_UNCENT  = 8'h40; // uncentered coarse start
  localparam logic [7:0] LHC_IDX_C720    = 8'h41; // 720-dot centered start
  localparam logic [7:0] LHC_IDX_C640    = 8'h42; // 640-dot centered start
  localparam logic [7:0] LHC_IDX_FINE    = 8'h43; // fine delay and line-clock width
  localparam logic [7:0] LHC_IDX_WIDTH   = 8'h44; // panel display width
  // ----------------------------------------
  // reset values and fields
  // ----------------------------------------
  localparam logic [7:0] LHC_RST_BYTE    = 8'h00; // reset value of every register
  localparam logic [7:0] LHC_FINE_MASK   = 8'h7f; // bit 7 reserved, reads zero
  localparam int         LHC_FD_UNC_LO   = 0;     // uncentered fine field low bit
  localparam int         LHC_FD_720_LO   = 2;     // 720 fine field low bit
  localparam int         LHC_FD_640_LO   = 4;     // 640 fine field low bit
  localparam int         LHC_LCW_BIT     = 6;     // line-clock width select
  localparam logic [7:0] LHC_HDE_LIMIT   = 8'h50; // crt display-enable threshold
  // ----------------------------------------
  // timing constants
  // ----------------------------------------
  localparam int         LHC_UNIT_SHIFT  = 2;     // coarse unit is 4 dot clocks
  localparam logic [3:0] LHC_LCW_NARROW  = 4'h4;  // line clock 4 dot clocks
  localparam logic [3:0] LHC_LCW_WIDE    = 4'h8;  // line clock 8 dot clocks
  localparam logic [10:0] LHC_POS_ONE    = 11'h001; // one-less compensation step
  // ----------------------------------------
  // selection and carrier types
  // ----------------------------------------
  typedef enum logic [1:0]
  {
    LHC_SEL_UNC = 2'b00,
    LHC_SEL_720 = 2'b01,
    LHC_SEL_640 = 2'b10
  } lhc_sel_t;
  typedef struct packed
  {
    logic       panel_800;   // panel is 800x600
    logic       gfx_800;     // 800x600 graphics mode active
    logic       text_mode;   // text mode (else graphics)
    logic       char_9;      // character clock 9 dots (else 8)
    logic       hexpand;     // horizontal expansion on
    logic [7:0] crt_hde;     // crt display-enable value
  } lhc_mode_t;
  typedef struct packed
  {
    logic       wr;          // write strobe
    logic       rd;          // read strobe
    logic [7:0] idx;         // register index
    logic [7:0] wdata;       // write data
  } lhc_req_t;
endpackage

/* File: lhc_start_center.sv */
// lcd display-enable and line-clock start generator with automatic centering
`timescale 1ns/1ps
module lhc_start_center
  import lhc_pkg::*;
(
  input  wire logic      core_clk_i,   // dot clock, 200 MHz
  input  wire logic      arst_n_i,     // async reset, active low
  input  wire lhc_req_t  req_i,        // indexed register access
  output logic [7:0]     rdata_o,      // read data, registered
  input  wire logic      crt_hstart_i, // crt display-enable start pulse
  input  wire lhc_mode_t mode_i,       // current mode conditions
  input  wire logic      pix_valid_i,  // pixel data from pipeline
  output logic           lcd_hde_o,    // lcd display-enable start pulse
  output logic           lcd_lclk_o,   // lcd line clock
  output logic           pix_send_o,   // pixel data forwarded to panel
  output logic [1:0]     sel_o         // active coarse register
);
  // ----------------------------------------
  // register file
  // ----------------------------------------
  logic [7:0] start_uncentered_reg;  // uncentered coarse start
  logic [7:0] start_center_720_reg;  // 720-dot coarse start
  logic [7:0] start_center_640_reg;  // 640-dot coarse start
  logic [7:0] fine_delay_ctrl_reg;   // fine fields and width bit
  logic [7:0] panel_width_reg;       // stored only, used elsewhere
  wire        wr_unc  = req_i.wr && (req_i.idx == LHC_IDX_UNCENT); // decode uncentered
  wire        wr_720  = req_i.wr && (req_i.idx == LHC_IDX_C720);   // decode 720
  wire        wr_640  = req_i.wr && (req_i.idx == LHC_IDX_C640);   // decode 640
  wire        wr_fine = req_i.wr && (req_i.idx == LHC_IDX_FINE);   // decode fine
  wire        wr_wid  = req_i.wr && (req_i.idx == LHC_IDX_WIDTH);  // decode width
  logic [7:0] rdata_next;            // read mux output
  always_comb
  begin
    unique case (req_i.idx)
      LHC_IDX_UNCENT: rdata_next = start_uncentered_reg;
      LHC_IDX_C720:   rdata_next = start_center_720_reg;
      LHC_IDX_C640:   rdata_next = start_center_640_reg;
      LHC_IDX_FINE:   rdata_next = fine_delay_ctrl_reg;
      LHC_IDX_WIDTH:  rdata_next = panel_width_reg;
      default:        rdata_next = LHC_RST_BYTE; // other indices not ours
    endcase
  end
  // register writes; reserved bit 7 of the fine register is never stored
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      start_uncentered_reg <= LHC_RST_BYTE;
      start_center_720_reg <= LHC_RST_BYTE;
      start_center_640_reg <= LHC_RST_BYTE;
      fine_delay_ctrl_reg  <= LHC_RST_BYTE;
      panel_width_reg      <= LHC_RST_BYTE;
      rdata_o              <= LHC_RST_BYTE;
    end
    else
    begin
      if (wr_unc)  start_uncentered_reg <= req_i.wdata;
      if (wr_720)  start_center_720_reg <= req_i.wdata;
      if (wr_640)  start_center_640_reg <= req_i.wdata;
      if (wr_fine) fine_delay_ctrl_reg  <= req_i.wdata & LHC_FINE_MASK;
      if (wr_wid)  panel_width_reg      <= req_i.wdata;
      if (req_i.rd) rdata_o <= rdata_next;
    end
  end
  // ----------------------------------------
  // automatic coarse selection
  // ----------------------------------------
  // both centered choices need an 800 panel, no 800 graphics, no expansion
  wire center_ok = mode_i.panel_800 && !mode_i.gfx_800 && !mode_i.hexpand;
  wire hde_big   = mode_i.crt_hde > LHC_HDE_LIMIT;
  wire use_720   = center_ok && (mode_i.text_mode ? mode_i.char_9 : hde_big);
  wire use_640   = center_ok && !mode_i.char_9 && !hde_big && !use_720;
  lhc_sel_t sel_now;                 // selection for this line
  // priority makes the choice one-hot; anything else falls to uncentered
  assign sel_now = use_720 ? LHC_SEL_720 : (use_640 ? LHC_SEL_640 : LHC_SEL_UNC);
  // ----------------------------------------
  // start position arithmetic
  // ----------------------------------------
  wire [7:0]  coarse_sel = (sel_now == LHC_SEL_720) ? start_center_720_reg :
                           (sel_now == LHC_SEL_640) ? start_center_640_reg :
                           start_uncentered_reg;
  wire [1:0]  fine_sel   = (sel_now == LHC_SEL_720) ? fine_delay_ctrl_reg[LHC_FD_720_LO +: 2] :
                           (sel_now == LHC_SEL_640) ? fine_delay_ctrl_reg[LHC_FD_640_LO +: 2] :
                           fine_delay_ctrl_reg[LHC_FD_UNC_LO +: 2];
  // centered values are stored one less than the start parameter
  wire        is_center  = (sel_now != LHC_SEL_UNC);
  wire [10:0] coarse_pos = {1'b0, coarse_sel, 2'b00};
  wire [10:0] pos_next   = coarse_pos + {9'h000, fine_sel}
                           + (is_center ? (LHC_POS_ONE << LHC_UNIT_SHIFT) : 11'h000);
  // ----------------------------------------
  // lcd horizontal counter
  // ----------------------------------------
  logic        restart_reg;          // crt start delayed one dot
  logic [10:0] hcnt_reg;             // dot count since lcd restart
  logic [10:0] pos_reg;              // start position latched per line
  logic        armed_reg;            // start not yet issued this line
  logic        hde_reg;              // start pulse
  logic [3:0]  lclk_cnt_reg;         // remaining line-clock dots
  logic [1:0]  sel_reg;              // selection latched per line
  wire  [3:0]  lclk_len = fine_delay_ctrl_reg[LHC_LCW_BIT] ? LHC_LCW_WIDE : LHC_LCW_NARROW;
  // lcd counter starts one dot after the crt one, so both sides see value minus one
  wire         hit      = armed_reg && !restart_reg && (hcnt_reg == pos_reg);
  // the line value is latched at restart so a mid-line mode change cannot tear it
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      restart_reg  <= 1'b0;
      hcnt_reg     <= 11'h000;
      pos_reg      <= 11'h000;
      armed_reg    <= 1'b0;
      hde_reg      <= 1'b0;
      lclk_cnt_reg <= 4'h0;
      sel_reg      <= LHC_SEL_UNC;
    end
    else
    begin
      restart_reg <= crt_hstart_i;
      hde_reg     <= hit;
      if (restart_reg)
      begin
        hcnt_reg  <= 11'h000;
        pos_reg   <= pos_next;
        sel_reg   <= sel_now;
        armed_reg <= 1'b1;
      end
      else
      begin
        hcnt_reg <= hcnt_reg + 11'h001;
        if (hit) armed_reg <= 1'b0;
      end
      if (hit)
        lclk_cnt_reg <= lclk_len;
      else if (lclk_cnt_reg != 4'h0)
        lclk_cnt_reg <= lclk_cnt_reg - 4'h1;
    end
  end
  assign lcd_hde_o  = hde_reg;
  assign lcd_lclk_o = (lclk_cnt_reg != 4'h0);
  assign sel_o      = sel_reg;
  // pixel data is released in the same cycle as the enable start pulse
  logic send_reg;                    // display active on this line
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      send_reg <= 1'b0;
    else if (restart_reg)
      send_reg <= 1'b0;
    else if (hit)
      send_reg <= 1'b1;
  end
  assign pix_send_o = send_reg && pix_valid_i;
  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence line_start_s;
    restart_reg;
  endsequence
  // the line value is fixed at restart, so each start check looks one edge later
  sequence latch_unc_s;
    restart_reg && (sel_now == LHC_SEL_UNC);
  endsequence
  sequence latch_720_s;
    restart_reg && (sel_now == LHC_SEL_720);
  endsequence
  sequence latch_640_s;
    restart_reg && (sel_now == LHC_SEL_640);
  endsequence
  property lclk_width_p;
    @(posedge core_clk_i) disable iff (!arst_n_i)
    $rose(lcd_hde_o) |-> lcd_lclk_o [*4];
  endproperty
  lclk_min_a: assert property (lclk_width_p)
    else $error("line clock shorter than four dots");
  // the width bit counts as it stood at the hit edge, one cycle before the pulse shows
  lclk_wide_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    (hde_reg && $past(fine_delay_ctrl_reg[LHC_LCW_BIT])) |-> lcd_lclk_o [*8])
    else $error("wide line clock shorter than eight dots");
  sel_expand_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    mode_i.hexpand |-> sel_now == LHC_SEL_UNC)
    else $error("centering used during expansion");
  sel_onehot_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    sel_now != 2'b11)
    else $error("illegal coarse selection");
  sel_720_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    (center_ok && mode_i.text_mode && mode_i.char_9) |-> sel_now == LHC_SEL_720)
    else $error("720 centering not chosen");
  sel_640_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    (center_ok && !mode_i.char_9 && !hde_big) |-> sel_now == LHC_SEL_640)
    else $error("640 centering not chosen");
  // position latched at restart rebuilt from the registers as they stood then
  start_pos_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    latch_unc_s |=> pos_reg == {1'b0, $past(start_uncentered_reg),
                                $past(fine_delay_ctrl_reg[LHC_FD_UNC_LO +: 2])})
    else $error("start at wrong position");
  center_720_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    latch_720_s |=> (pos_reg[10:2] == {1'b0, $past(start_center_720_reg)} + 9'h001) &&
                    (pos_reg[1:0] == $past(fine_delay_ctrl_reg[LHC_FD_720_LO +: 2])))
    else $error("720 centered start at wrong position");
  center_640_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    latch_640_s |=> (pos_reg[10:2] == {1'b0, $past(start_center_640_reg)} + 9'h001) &&
                    (pos_reg[1:0] == $past(fine_delay_ctrl_reg[LHC_FD_640_LO +: 2])))
    else $error("640 centered start at wrong position");
  // a second pulse needs a fresh restart, so the start never lasts two dots
  hde_once_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    lcd_hde_o |=> !lcd_hde_o)
    else $error("display-enable start longer than one dot");
  restart_one_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    crt_hstart_i |=> line_start_s ##1 (hcnt_reg == 11'h000))
    else $error("lcd counter not restarted one dot later");
  send_after_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    (hde_reg && !restart_reg && pix_valid_i) |-> pix_send_o)
    else $error("pixel data late after start");
endmodule

/* File: lhc_panel_model.sv */
// far-side panel model that measures the lcd line-clock pulse width
`timescale 1ns/1ps
module lhc_panel_model
  import lhc_pkg::*;
(
  input  wire logic       core_clk_i,   // dot clock
  input  wire logic       arst_n_i,     // async reset, active low
  input  wire logic       lcd_lclk_i,   // line clock from the block
  output logic [3:0]      lclk_width_o  // width of the last line-clock pulse
);
  logic [3:0] run_reg;                  // dot clocks seen high so far
  // ----------------------------------------
  // pulse width capture
  // ----------------------------------------
  // a panel only latches on the falling edge, so width is known once it ends
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      run_reg      <= 4'h0;
      lclk_width_o <= 4'h0;
    end
    else if (lcd_lclk_i)
      run_reg <= run_reg + 4'h1;
    else if (run_reg != 4'h0)
    begin
      lclk_width_o <= run_reg;
      run_reg      <= 4'h0;
    end
  end
endmodule

/* File: tb.sv */
// self-checking testbench for the lcd start centering block
`timescale 1ns/1ps
module tb;
  import lhc_pkg::*;
  logic       core_clk_i = 1'b0;   // dot clock
  logic       arst_n_i = 1'b0;     // reset, active low
  logic       crt_hstart_i = 1'b0; // crt start pulse
  logic       pix_valid_i = 1'b1;  // pixel data available
  lhc_req_t   req_i = '0;          // register access
  lhc_mode_t  mode_i = '0;         // mode conditions
  logic [7:0] rdata_o;             // read data
  logic       lcd_hde_o;           // display-enable start
  logic       lcd_lclk_o;          // line clock
  logic       pix_send_o;          // pixel forward
  logic [1:0] sel_o;               // active coarse register
  logic [3:0] lclk_width;          // measured by panel model
  int         n_fail = 0;          // mismatches
  int         num_checks = 0;      // comparisons
  int         cyc = 0;             // cycle counter for timeout
  lhc_start_center dut (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .req_i(req_i),
    .rdata_o(rdata_o), .crt_hstart_i(crt_hstart_i), .mode_i(mode_i),
    .pix_valid_i(pix_valid_i), .lcd_hde_o(lcd_hde_o), .lcd_lclk_o(lcd_lclk_o),
    .pix_send_o(pix_send_o), .sel_o(sel_o));
  lhc_panel_model panel (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i),
    .lcd_lclk_i(lcd_lclk_o), .lclk_width_o(lclk_width));
  always #2.5 core_clk_i = ~core_clk_i;
  // ----------------------------------------
  // common tasks
  // ----------------------------------------
  task test_done();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // a hang in any handshake loop ends here instead of running forever
  always @(posedge core_clk_i)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_fail++;
      test_done();
    end
  end
  task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp)
    begin
      $display("ERROR %s expected %h seen %h", what, exp, got);
      n_fail++;
    end
  endtask
  // all driving happens 1 ns after a rising edge
  task wr(input logic [7:0] idx, input logic [7:0] d);
    req_i = '{wr: 1'b1, rd: 1'b0, idx: idx, wdata: d};
    @(posedge core_clk_i);
    #1 req_i = '0;
    // one idle edge so the next request never overwrites the clear in one time step
    @(posedge core_clk_i);
    #1;
  endtask
  task rd_chk(input logic [7:0] idx, input logic [7:0] exp);
    req_i = '{wr: 1'b0, rd: 1'b1, idx: idx, wdata: 8'h00};
    @(posedge core_clk_i);
    #1 req_i = '0;
    @(posedge core_clk_i);
    #1 chk("rdata", exp, rdata_o);
  endtask
  function automatic lhc_mode_t mk(logic p8, logic g8, logic tx, logic c9, logic hx,
                                   logic [7:0] horizontal_display_enable);
    return '{panel_800: p8, gfx_800: g8, text_mode: tx, char_9: c9, hexpand: hx,
             crt_hde: horizontal_display_enable};
  endfunction
  // one scanline: start latency, selection, pixel flow and line-clock width
  task line_chk(input lhc_mode_t m, input logic [1:0] es, input int pos,
                input logic [3:0] ew);
    int n;
    logic early;
    mode_i = m;
    crt_hstart_i = 1'b1;
    n = 0;
    early = 1'b0;
    @(posedge core_clk_i);
    #1 crt_hstart_i = 1'b0;
    while (lcd_hde_o !== 1'b1 && n < 400)
    begin
      @(posedge core_clk_i);
      #1 n++;
      // the restart clears the previous line's flow before the new start
      if (lcd_hde_o !== 1'b1)
        early = early | pix_send_o;
    end
    // counter restarts an edge after the crt start, and the pulse is registered
    chk("start delay", 8'(2 + pos), 8'(n));
    chk("pixel early", 8'h00, {7'h00, early});
    chk("selection", {6'h00, es}, {6'h00, sel_o});
    chk("pixel send", 8'h01, {7'h00, pix_send_o});
    chk("line clock", 8'h01, {7'h00, lcd_lclk_o});
    repeat (12) @(posedge core_clk_i);
    #1 chk("line width", {4'h0, ew}, {4'h0, lclk_width});
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    repeat (2) @(posedge core_clk_i);
    #1 arst_n_i = 1'b1;
    rd_chk(LHC_IDX_UNCENT, 8'h00);
    rd_chk(LHC_IDX_C720, 8'h00);
    rd_chk(LHC_IDX_C640, 8'h00);
    rd_chk(LHC_IDX_FINE, 8'h00);
    rd_chk(LHC_IDX_WIDTH, 8'h00);
    // software programs the start values the way the panel side expects
    wr(LHC_IDX_UNCENT, 8'h02);
    wr(LHC_IDX_C720, 8'h03);
    wr(LHC_IDX_C640, 8'h01);
    wr(LHC_IDX_FINE, 8'hf9);
    wr(LHC_IDX_WIDTH, 8'ha4);
    wr(8'h45, 8'h5a);
    rd_chk(LHC_IDX_UNCENT, 8'h02);
    rd_chk(LHC_IDX_C720, 8'h03);
    rd_chk(LHC_IDX_C640, 8'h01);
    rd_chk(LHC_IDX_FINE, 8'h79);
    rd_chk(LHC_IDX_WIDTH, 8'ha4);
    rd_chk(8'h45, 8'h00);
    line_chk(mk(0, 0, 1, 1, 0, 8'h51), 2'd0, 9, 4'h8);
    line_chk(mk(1, 0, 1, 1, 1, 8'h00), 2'd0, 9, 4'h8);
    line_chk(mk(1, 1, 0, 0, 0, 8'h60), 2'd0, 9, 4'h8);
    line_chk(mk(1, 0, 1, 1, 0, 8'h00), 2'd1, 18, 4'h8);
    line_chk(mk(1, 0, 0, 0, 0, 8'h51), 2'd1, 18, 4'h8);
    line_chk(mk(1, 0, 0, 0, 0, 8'h50), 2'd2, 11, 4'h8);
    line_chk(mk(1, 0, 1, 0, 0, 8'h50), 2'd2, 11, 4'h8);
    wr(LHC_IDX_FINE, 8'h00);
    line_chk(mk(0, 0, 1, 0, 0, 8'h10), 2'd0, 8, 4'h4);
    line_chk(mk(1, 0, 1, 1, 0, 8'h10), 2'd1, 16, 4'h4);
    test_done();
  end
endmodule
